// *** core/rtc_pkg.sv ***
/*
 * Constants, register map and carrier types for the real-time counter
 * with periodic tick. Assumes a 32-bit plain register port and a single
 * 100 MHz system clock.
 */
package rtc_pkg;

  // System clock
  localparam int unsigned SYS_CLK_HZ = 100_000_000;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FLAGS = 8'h04;
  localparam logic [7:0] OFS_ENABLES = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0C;
  localparam logic [7:0] OFS_PERIOD = 8'h10;
  localparam logic [7:0] OFS_COMPARE = 8'h14;
  localparam logic [7:0] OFS_CLKSEL = 8'h18;
  localparam logic [7:0] OFS_TICKCTRL = 8'h1C;
  localparam logic [7:0] OFS_DEBUG = 8'h20;

  // Field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_PRESC_LSB = 3;
  localparam int TICK_EN_BIT = 0;
  localparam int TICK_PER_LSB = 1;
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CMP_BIT = 1;
  localparam int FLAG_TICK_BIT = 2;
  localparam int EVT_OVF_BIT = 4;
  localparam int EVT_CMP_BIT = 5;

  // Reset values
  localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;
  localparam logic [3:0] TICK_PER_RESET = 4'h1;

  // Widths and tick ranges
  localparam int COUNT_W = 16;
  localparam int PRESC_W = 15;
  localparam int TICK_EVT_LO = 5;   // 64 count-clock cycles
  localparam int TICK_EVT_HI = 12;  // 8192 count-clock cycles
  localparam int TICK_EVT_N = TICK_EVT_HI - TICK_EVT_LO + 1;
  localparam logic [3:0] TICK_SEL_MIN = 4'h1;  // 4 cycles
  localparam logic [3:0] TICK_SEL_MAX = 4'hE;  // 32768 cycles
  localparam int ULP_DIV_W = 5;     // divide by 32

  // Reference clock sources
  typedef enum logic [1:0] {
    SRC_CRYSTAL = 2'b00,
    SRC_EXTERNAL = 2'b01,
    SRC_LOW_POWER = 2'b10,
    SRC_LOW_POWER_DIV32 = 2'b11
  } clk_src_e;

  // Software configuration carried as one bundle
  typedef struct packed {
    logic counter_enable_bit;
    logic [3:0] presc_sel;
    logic tick_enable_bit;
    logic [3:0] tick_sel;
    logic debug_run_bit;
    logic [5:0] enables;
    logic [15:0] period;
    logic [15:0] compare;
  } config_s;

endpackage

// *** core/rtc_tick_counter.sv ***
/*
 * Real-time counter with compare, overflow and periodic tick outputs.
 * Everything runs on ref_clk_i; the selected reference pin only makes a
 * one-cycle count enable, so there is no second clock domain to cross.
 * Holds the register port, the shared 15-bit prescaler, the 16-bit
 * counter with its compare and period match, and the tick squares.
 * Assumes the reference clocks arrive as slow pins asynchronous to
 * ref_clk_i, each well below a quarter of the system clock rate.
 * Assumes cpu_halted_i comes from logic on ref_clk_i, so it is not
 * synchronised here.
 * Assumes software picks the reference source before enabling either
 * function; a later pick waits until both are off again.
 */
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// - 16-bit counter advances per prescaled clock
// - Four selectable reference clock sources
// - 15-bit prescaler divides the reference clock
// - Compare fires on advance after match
// - Overflow fires on advance after period match
// - Overflow returns counter to zero
// - Each source optionally raises interrupt, event; here the tick events have no enable bit and run whenever the tick is enabled
// - Tick enable independent of counter enable
// - Tick uses same count clock
// - Tick interrupt every 4 to 32768
// - Tick events every 64 to 8192
// - Counter runs in sleep, interrupts wake
// - Stops on debugger halt unless debug-run
// - Debug-run set keeps counting while halted
// - Prescaler off while both functions off
// - Tick output is square, full period
// - Enable bit starts and stops counter
module rtc_tick_counter (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic crystal_clk_i,
  input wire logic ext_clk_i,
  input wire logic low_power_clk_i,
  input wire logic cpu_halted_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rd_data_o,
  output logic ovf_irq_o,
  output logic cmp_irq_o,
  output logic tick_irq_o,
  output logic ovf_event_o,
  output logic cmp_event_o,
  output logic [rtc_pkg::TICK_EVT_N-1:0] tick_event_o
);
  import rtc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection

  // Synchroniser stages, edge detect and low-power divider
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [2:0] pin_prev;
  logic [2:0] pin_rise;
  logic [ULP_DIV_W-1:0] ulp_div;
  logic ulp_div_tick;

  // Two flops per pin; only the second stage is looked at
  // Reset clears the stages, so a pin high at release counts one edge
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
      pin_prev <= 3'h0;
    end else begin
      pin_meta <= {low_power_clk_i, ext_clk_i, crystal_clk_i};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Rising edge of each synced pin, one cycle wide
  assign pin_rise = pin_sync & ~pin_prev;

  // Divide-by-32 of the low-power oscillator
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ulp_div <= '0;
    end else if (pin_rise[2]) begin
      ulp_div <= ulp_div + 1'b1;
    end
  end

  // Fires on the rise that wraps the divider
  assign ulp_div_tick = pin_rise[2] && (ulp_div == {ULP_DIV_W{1'b1}});

  ////////////////////////////////////////////////////////////////////////
  // Software registers

  // Live configuration and the pending source request
  config_s cfg;
  clk_src_e src_req;
  clk_src_e src_active;
  logic [2:0] flags;
  logic any_enabled;

  // Write decodes, one per writable register; the count has none
  wire wr_ctrl = wr_i && (addr_i == OFS_CTRL);
  wire wr_flags = wr_i && (addr_i == OFS_FLAGS);
  wire wr_enables = wr_i && (addr_i == OFS_ENABLES);
  wire wr_period = wr_i && (addr_i == OFS_PERIOD);
  wire wr_compare = wr_i && (addr_i == OFS_COMPARE);
  wire wr_clksel = wr_i && (addr_i == OFS_CLKSEL);
  wire wr_tick = wr_i && (addr_i == OFS_TICKCTRL);
  wire wr_debug = wr_i && (addr_i == OFS_DEBUG);

  // Configuration writes; tick period clamped into its legal range
  // Write bits outside the defined fields are ignored
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cfg.counter_enable_bit <= 1'b0;
      cfg.presc_sel <= 4'h0;
      cfg.tick_enable_bit <= 1'b0;
      cfg.tick_sel <= TICK_PER_RESET;
      cfg.debug_run_bit <= 1'b0;
      cfg.enables <= 6'h00;
      cfg.period <= PERIOD_RESET;
      cfg.compare <= COMPARE_RESET;
      src_req <= SRC_CRYSTAL;
    end else begin
      if (wr_ctrl) begin
        cfg.counter_enable_bit <= wr_data_i[CTRL_EN_BIT];
        cfg.presc_sel <= wr_data_i[CTRL_PRESC_LSB +: 4];
      end
      if (wr_tick) begin
        cfg.tick_enable_bit <= wr_data_i[TICK_EN_BIT];
        cfg.tick_sel <= (wr_data_i[TICK_PER_LSB +: 4] < TICK_SEL_MIN) ? TICK_SEL_MIN :
                        (wr_data_i[TICK_PER_LSB +: 4] > TICK_SEL_MAX) ? TICK_SEL_MAX :
                        wr_data_i[TICK_PER_LSB +: 4];
      end
      if (wr_debug) begin
        cfg.debug_run_bit <= wr_data_i[0];
      end
      if (wr_enables) begin
        cfg.enables <= wr_data_i[5:0];
      end
      if (wr_period) begin
        cfg.period <= wr_data_i[15:0];
      end
      if (wr_compare) begin
        cfg.compare <= wr_data_i[15:0];
      end
      if (wr_clksel) begin
        src_req <= clk_src_e'(wr_data_i[1:0]);
      end
    end
  end

  // Either function running releases the prescaler from zero and locks the source; presc_sel stays writable
  assign any_enabled = cfg.counter_enable_bit || cfg.tick_enable_bit;

  // Active source follows the request only while everything is off
  // Switching under a running count could split one count clock
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      src_active <= SRC_CRYSTAL;
    end else if (!any_enabled) begin
      src_active <= src_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Count clock, halt gating and prescaler

  // Count enable path
  logic src_tick;
  logic run_ok;
  logic count_tick;
  logic [PRESC_W-1:0] presc;
  logic [PRESC_W-1:0] presc_mask;
  logic counter_advance;

  // Selected reference edge as a one-cycle enable
  // The divided source is already an enable from the low-power divider
  always_comb begin
    case (src_active)
      SRC_CRYSTAL: src_tick = pin_rise[0];
      SRC_EXTERNAL: src_tick = pin_rise[1];
      SRC_LOW_POWER: src_tick = pin_rise[2];
      SRC_LOW_POWER_DIV32: src_tick = ulp_div_tick;
      default: src_tick = 1'b0;
    endcase
  end

  // Halt gating; debug-run keeps counting under a halted core
  assign run_ok = !cpu_halted_i || cfg.debug_run_bit;
  assign count_tick = src_tick && run_ok;

  // Shared prescaler, held at zero while both functions are off
  // Clearing it when idle puts the first tick half a period out
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || !any_enabled) begin
      presc <= '0;
    end else if (count_tick) begin
      presc <= presc + 1'b1;
    end
  end

  // Advance once every 2^presc_sel count clocks
  // Select 0 gives an empty mask and an advance on every count clock
  assign presc_mask = PRESC_W'((32'h1 << cfg.presc_sel) - 32'h1);
  assign counter_advance = cfg.counter_enable_bit && count_tick &&
                           ((presc & presc_mask) == presc_mask);

  ////////////////////////////////////////////////////////////////////////
  // Counter, compare and overflow

  // Counter state and the two match strobes
  logic [COUNT_W-1:0] count;
  logic ovf_hit;
  logic cmp_hit;

  // Matches use the value before the advance, so they fire one step late
  assign ovf_hit = counter_advance && (count == cfg.period);
  assign cmp_hit = counter_advance && (count == cfg.compare);

  // Keeps going whatever the sleep state; only enable and halt stop it
  // Disabling holds the count; only reset or an overflow clears it
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      count <= '0;
    end else if (ovf_hit) begin
      count <= '0;
    end else if (counter_advance) begin
      count <= count + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Periodic tick

  // Tick level, its last value and the gated prescaler copy
  logic tick_level;
  logic tick_prev;
  logic tick_rise;
  logic [PRESC_W-1:0] tick_bits;

  // Gated prescaler bits; the selected bit is a square wave
  // Enabling the tick while the counter runs can give an early first edge
  assign tick_bits = cfg.tick_enable_bit ? presc : '0;
  assign tick_level = tick_bits[cfg.tick_sel];
  assign tick_rise = tick_level && !tick_prev;

  // Last tick level for the rising-edge detect
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      tick_prev <= 1'b0;
    end else begin
      tick_prev <= tick_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky flags, requests and events

  // Match strobes per flag and the flag next state
  logic [2:0] hits;
  logic [2:0] next_flags;

  // All indications come from the sampled count clock, so software sees
  // only system-clock-aligned values
  assign hits = {tick_rise, cmp_hit, ovf_hit};

  // Set beats a simultaneous write-one clear
  // A tick edge landing on a clear is never lost
  assign next_flags = hits | (flags & ~(wr_flags ? wr_data_i[2:0] : 3'h0));

  // Requests follow the flags in the same cycle; events are single pulses
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      flags <= 3'h0;
      ovf_irq_o <= 1'b0;
      cmp_irq_o <= 1'b0;
      tick_irq_o <= 1'b0;
      ovf_event_o <= 1'b0;
      cmp_event_o <= 1'b0;
    end else begin
      flags <= next_flags;
      ovf_irq_o <= next_flags[FLAG_OVF_BIT] && cfg.enables[FLAG_OVF_BIT];
      cmp_irq_o <= next_flags[FLAG_CMP_BIT] && cfg.enables[FLAG_CMP_BIT];
      tick_irq_o <= next_flags[FLAG_TICK_BIT] && cfg.enables[FLAG_TICK_BIT];
      ovf_event_o <= ovf_hit && cfg.enables[EVT_OVF_BIT];
      cmp_event_o <= cmp_hit && cfg.enables[EVT_CMP_BIT];
    end
  end

  // Event taps at 64 .. 8192 count clocks, square while tick enabled
  // Each tap is registered so the event router sees clean levels
  genvar gi;
  generate
    for (gi = 0; gi < TICK_EVT_N; gi = gi + 1) begin : g_tick_evt
      always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
          tick_event_o[gi] <= 1'b0;
        end else begin
          tick_event_o[gi] <= tick_bits[TICK_EVT_LO + gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Read port, one cycle latency

  // Selected register ahead of the output flop
  logic [31:0] rd_mux;

  // Count read is direct; the bus clock limit keeps it stable
  // Unmapped offsets read as zero
  always_comb begin
    case (addr_i)
      OFS_CTRL: rd_mux = {25'h0, cfg.presc_sel, 2'h0, cfg.counter_enable_bit};
      OFS_FLAGS: rd_mux = {29'h0, flags};
      OFS_ENABLES: rd_mux = {26'h0, cfg.enables};
      OFS_COUNT: rd_mux = {16'h0, count};
      OFS_PERIOD: rd_mux = {16'h0, cfg.period};
      OFS_COMPARE: rd_mux = {16'h0, cfg.compare};
      OFS_CLKSEL: rd_mux = {28'h0, src_active, src_req};
      OFS_TICKCTRL: rd_mux = {27'h0, cfg.tick_sel, cfg.tick_enable_bit};
      OFS_DEBUG: rd_mux = {31'h0, cfg.debug_run_bit};
      default: rd_mux = 32'h0;
    endcase
  end

  // Data stands only in the cycle after the strobe
  // Zero between answers, so a stray sample never shows stale data
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rd_data_o <= 32'h0;
    end else begin
      rd_data_o <= rd_i ? rd_mux : 32'h0;
    end
  end

endmodule

// *** tb/rtc_osc_model.sv ***
/* Oscillator model for the three reference pins.
   Assumes a 10 ns system clock rising at 5 ns past each 10 ns. */
`timescale 1ns/1ps
module rtc_osc_model (
  output logic crystal_clk_o,
  output logic ext_clk_o,
  output logic low_power_clk_o
);
  // Free-running; edges stay off rising system edges, periods of 6+ clocks
  initial begin
    crystal_clk_o = 1'h0;
    forever #40 crystal_clk_o = ~crystal_clk_o;
  end
  initial begin
    ext_clk_o = 1'h0;
    forever #50 ext_clk_o = ~ext_clk_o;
  end
  initial begin
    low_power_clk_o = 1'h0;
    forever #30 low_power_clk_o = ~low_power_clk_o;
  end
endmodule

// *** tb/rtc_tick_counter_assertions.sv ***
/* Port checker for the real-time counter.
   Assumes it is bound to the top module. */
`timescale 1ns/1ps
module rtc_tick_counter_checker (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic cpu_halted_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rd_data_o,
  input wire logic ovf_irq_o,
  input wire logic tick_irq_o,
  input wire logic ovf_event_o,
  input wire logic cmp_event_o,
  input wire logic [rtc_pkg::TICK_EVT_N-1:0] tick_event_o
);
  import rtc_pkg::*;
  logic dbg;
  logic [2:0] held;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////
  // Debug-run copy; halted cycles saturate at 7, covering sync latency
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) dbg <= 1'h0;
    else if (wr_i && addr_i == OFS_DEBUG) dbg <= wr_data_i[0];
  end
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || wr_i || !cpu_halted_i || dbg) held <= 3'h0;
    else if (held != 3'h7) held <= held + 3'h1;
  end
  ////////////////////////////////////////
  rd_idle_a: assert property (!$past(rd_i) |-> rd_data_o == 32'h0)
    else $error("read data without read");
  count_hi_a: assert property ($past(rd_i && addr_i == OFS_COUNT) |-> rd_data_o[31:16] == 16'h0)
    else $error("count upper bits set");
  ovf_pulse_a: assert property (ovf_event_o |=> !ovf_event_o)
    else $error("overflow event too long");
  cmp_pulse_a: assert property (cmp_event_o |=> !cmp_event_o)
    else $error("compare event too long");
  halt_stop_a: assert property (held == 3'h7 |-> !ovf_event_o && !cmp_event_o && $stable(tick_event_o))
    else $error("counting while halted");
  tick_off_a: assert property (wr_i && addr_i == OFS_TICKCTRL && !wr_data_i[0] |-> ##[1:4] tick_event_o == '0)
    else $error("tick squares stay on");
  tick_chain_a: assert property ($rose(tick_event_o[1]) && |$past(tick_event_o) |-> $fell(tick_event_o[0]))
    else $error("tick squares out of step");
  ovf_drop_a: assert property ($fell(ovf_irq_o) |-> $past(wr_i) || $past(wr_i, 2))
    else $error("overflow request dropped alone");
  tick_drop_a: assert property ($fell(tick_irq_o) |-> $past(wr_i) || $past(wr_i, 2))
    else $error("tick request dropped alone");
  cover property (ovf_event_o);
  cover property (held == 3'h7);
  cover property ($rose(tick_irq_o));
endmodule
bind rtc_tick_counter rtc_tick_counter_checker u_checker (.ref_clk_i, .reset_i, .cpu_halted_i, .addr_i,
  .wr_data_i, .wr_i, .rd_i, .rd_data_o, .ovf_irq_o, .tick_irq_o, .ovf_event_o, .cmp_event_o, .tick_event_o);

// *** tb/rtc_tick_counter_bench.sv ***
/* Self-checking bench for the real-time counter.
   Assumes the oscillator model on the reference pins. */
`timescale 1ns/1ps
module rtc_tick_counter_bench;
  import rtc_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] r, w, e;} row_s;
  row_s rows [7] = '{'{OFS_PERIOD, 32'hFFFF, 32'h2, 32'h2}, '{OFS_COMPARE, 32'h0, 32'h1, 32'h1},
    '{OFS_TICKCTRL, 32'h2, 32'h1C, 32'h1C}, '{OFS_DEBUG, 32'h0, 32'h1, 32'h1},
    '{OFS_ENABLES, 32'h0, 32'h37, 32'h37}, '{OFS_COUNT, 32'h0, 32'h5, 32'h0}, '{8'h40, 32'h0, 32'hFF, 32'h0}};
  int hp [4] = '{8, 10, 6, 192};
  logic ref_clk_i = 1'h0;
  logic reset_i = 1'h1;
  logic cpu_halted_i = 1'h0;
  logic wr_i = 1'h0;
  logic rd_i = 1'h0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wr_data_i = 32'h0;
  logic [31:0] rd_data_o, q, b;
  logic crystal_clk_i, ext_clk_i, low_power_clk_i, ovf_irq_o, cmp_irq_o, tick_irq_o, ovf_event_o, cmp_event_o;
  logic [TICK_EVT_N-1:0] tick_event_o;
  int n_errors = 0;
  int tests_run = 0;
  int c;
  always #5 ref_clk_i = ~ref_clk_i;
  rtc_osc_model u_rtc_osc_model (.crystal_clk_o(crystal_clk_i), .ext_clk_o(ext_clk_i),
    .low_power_clk_o(low_power_clk_i));
  rtc_tick_counter u_rtc_tick_counter (.ref_clk_i, .reset_i, .crystal_clk_i, .ext_clk_i, .low_power_clk_i,
    .cpu_halted_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o, .ovf_irq_o, .cmp_irq_o, .tick_irq_o,
    .ovf_event_o, .cmp_event_o, .tick_event_o);
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task complete_run;
    $display("checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Strobes last one edge; read data taken in the following cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'h1;
    @(posedge ref_clk_i);
    wr_i <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'h1;
    @(posedge ref_clk_i);
    rd_i <= 1'h0;
    @(negedge ref_clk_i);
    q = rd_data_o;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  // Cycles between two overflow pulses; the first may land mid-period
  task automatic span();
    c = 0;
    while (ovf_event_o !== 1'h1 && c < 20000) begin
      idle(1);
      c++;
    end
    c = 0;
    do begin
      idle(1);
      c++;
    end while (ovf_event_o !== 1'h1 && c < 20000);
  endtask
  task automatic flip();
    logic v;
    v = tick_event_o[0];
    c = 0;
    do begin
      idle(1);
      c++;
    end while (tick_event_o[0] === v && c < 1000);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge ref_clk_i);
    reset_i <= 1'h0;
    foreach (rows[i]) begin
      rd(rows[i].a);
      chk("reset value", rows[i].r, q);
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      chk("read back", rows[i].e, q);
    end
    wr(OFS_DEBUG, 32'h0);
    $display("register rows done");
    // Each source with its own prescale; a select made while running waits
    for (int s = 0; s < 4; s++) begin
      wr(OFS_CTRL, 32'h0);
      wr(OFS_CLKSEL, s);
      wr(OFS_CTRL, (s << CTRL_PRESC_LSB) | 1);
      wr(OFS_CLKSEL, s ^ 1);
      rd(OFS_CLKSEL);
      chk("active source", (s << 2) | (s ^ 1), q);
      span();
      chk("overflow spacing", (3 * hp[s]) << s, c);
      c = 0;
      do begin
        idle(1);
        c++;
      end while (cmp_event_o !== 1'h1 && c < 20000);
      chk("compare delay", (2 * hp[s]) << s, c);
    end
    wr(OFS_CTRL, 32'h0);
    rd(OFS_FLAGS);
    chk("flags", 32'h3, q & 32'h3);
    chk("requests", 32'h3, {ovf_irq_o, cmp_irq_o});
    wr(OFS_FLAGS, 32'h3);
    idle(2);
    chk("requests cleared", 32'h0, {ovf_irq_o, cmp_irq_o});
    $display("counting done");
    // Halted without debug-run the count freezes, with it the count moves
    wr(OFS_PERIOD, 32'hFFFF);
    wr(OFS_CTRL, 32'h1);
    cpu_halted_i <= 1'h1;
    idle(10);
    rd(OFS_COUNT);
    b = q;
    idle(100);
    rd(OFS_COUNT);
    chk("frozen count", b, q);
    wr(OFS_DEBUG, 32'h1);
    idle(100);
    rd(OFS_COUNT);
    chk("count moved", 32'h1, q !== b);
    @(posedge ref_clk_i);
    cpu_halted_i <= 1'h0;
    $display("debug halt done");
    // Tick alone on the low-power source: counter held, squares run
    wr(OFS_CTRL, 32'h0);
    wr(OFS_TICKCTRL, 32'h3);
    c = 0;
    while (tick_irq_o !== 1'h1 && c < 100) begin
      idle(1);
      c++;
    end
    chk("tick delay", 32'h1, c > 5 && c < 40);
    rd(OFS_COUNT);
    b = q;
    flip();
    flip();
    chk("tick half period", 32'hC0, c);
    rd(OFS_COUNT);
    chk("count held", b, q);
    idle(200);
    wr(OFS_TICKCTRL, 32'h0);
    wr(OFS_FLAGS, 32'h4);
    idle(4);
    chk("tick stopped", 32'h0, {tick_irq_o, tick_event_o});
    $display("tick done");
    // Reset in mid-run restores defaults
    wr(OFS_PERIOD, 32'h2);
    wr(OFS_CLKSEL, 32'h1);
    @(posedge ref_clk_i);
    reset_i <= 1'h1;
    repeat (2) @(posedge ref_clk_i);
    reset_i <= 1'h0;
    rd(OFS_PERIOD);
    chk("period after reset", 32'hFFFF, q);
    rd(OFS_CLKSEL);
    chk("source after reset", 32'h0, q);
    rd(OFS_FLAGS);
    chk("flags after reset", 32'h0, q);
    chk("outputs after reset", 32'h0, {ovf_irq_o, cmp_irq_o, tick_irq_o, ovf_event_o, cmp_event_o, tick_event_o});
    $display("reset done");
    complete_run();
  end
  // Run takes about 11k cycles; this limit is nearly four times that
  initial begin
    #420us;
    n_errors++;
    complete_run();
  end
endmodule
